// file: hw/gpc_debounce.sv
`timescale 1ns/1ps
module gpc_debounce #(
  parameter int CYCLES = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // Output follows only after the input held its new level CYCLES cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      q_o   <= 1'b0;
    end else if (d_i == q_o) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
      q_o   <= d_i;
    end else begin
      count <= count + CW'(1);
    end
  end

endmodule

// file: hw/gpc_pin_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Pull field 14:13: 00 none, 01 down, 10 up, 11 reserved; resets down.
// - Edge mode 0: interrupt on rising if polarity 1, falling if 0.
// - Edge mode 1: interrupt on both edges regardless of polarity.
// - Bit 11 picks supply: 0 digital I/O, 1 always-on internal; resets 0.
// - Polarity bit 10: 1 active high (reset), 0 inverted active low.
// - Bit 9: 0 push-pull (reset), 1 open drain pulling low only.
// - Enable bit 7 at 0 (reset) keeps pin tri-stated; 1 normal operation.
// - Bit 15: 1 input (reset), 0 output; input codes 0 long debounce, 1 plain.
// - Input codes 2 on/off, 3 sleep/wake, 4 same debounced, 5 sleep, 6 power-on.
// - Input code 7 watchdog reset; 8 and 9 voltage scaling selects.
// - Input 10/11 hardware enables; 12/13 controls; 14/15 controls debounced.
// - Output code 0 drives software level; code 1 drives 32.768kHz clock.
// - Output 2 ON state, 3 SLEEP state, 4 state change; 5-7 reserved.
// - Output 8/9 buck scaling done; 10/11 external power enables.
// - Output 12 system supply good, 13 converter power good.
// - Output 14 2MHz power clock, 15 auxiliary reset.
module gpc_pin_ctrl #(
  parameter int LONG_DEBOUNCE_CYCLES = gpc_pkg::LONG_DEBOUNCE_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [17:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               pin_in_i,
  output gpc_pkg::gpc_pad_t       pad_o,
  input  wire gpc_pkg::gpc_fn_vec_t out_src_i,
  output gpc_pkg::gpc_fn_vec_t    in_fn_o,
  output logic                    irq_o
);

  logic [15:0]          ctrl;
  logic [15:0]          level;
  logic [1:0]           irq_sts;
  logic [1:0]           irq_mask;
  logic                 pin_sync;
  logic                 pin_deb;
  gpc_pkg::gpc_fn_vec_t src_sync;
  logic                 sense;
  logic                 sense_q;
  logic                 raw_sel;
  logic                 raw_prev;
  logic                 raw_rise;
  logic                 raw_fall;
  logic                 sync_prev;
  logic                 deb_prev;
  logic                 edge_evt;
  logic                 fn_evt;
  gpc_pkg::gpc_fn_vec_t next_in_fn;
  gpc_pkg::gpc_pad_t    next_pad;
  logic [31:0]          next_rdata;
  logic                 bus_req;
  logic                 bus_wr;
  logic [15:0]          word_idx;
  logic [15:0]          wmask;
  logic                 sel_ctrl;
  logic                 sel_level;
  logic                 sel_sts;
  logic                 sel_mask;

  // Control fields
  logic       f_dir_in;
  logic [1:0] f_pull;
  logic       f_edge_both;
  logic       f_dom;
  logic       f_pol;
  logic       f_od;
  logic       f_ena;
  logic [3:0] f_fn;
  logic       in_mode;
  logic       out_mode;
  logic       long_deb;
  logic       out_rsvd;
  logic       out_level;
  logic       pin_level;

  assign f_dir_in    = ctrl[gpc_pkg::DIR_BIT];
  assign f_pull      = ctrl[gpc_pkg::PULL_HI:gpc_pkg::PULL_LO];
  assign f_edge_both = ctrl[gpc_pkg::EDGE_BIT];
  assign f_dom       = ctrl[gpc_pkg::DOM_BIT];
  assign f_pol       = ctrl[gpc_pkg::POL_BIT];
  assign f_od        = ctrl[gpc_pkg::OD_BIT];
  assign f_ena       = ctrl[gpc_pkg::ENA_BIT];
  assign f_fn        = ctrl[gpc_pkg::FN_HI:gpc_pkg::FN_LO];

  // Tri-state wins over direction: a disabled pin neither drives nor raises function lines or interrupts
  assign in_mode  = f_ena & f_dir_in;
  assign out_mode = f_ena & ~f_dir_in;

  // Wishbone slave
  // The registered ack masks the strobe it answers, so a held request is taken every second cycle
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i;
  assign word_idx  = wb_adr_i[17:2];
  assign sel_ctrl  = word_idx == gpc_pkg::CTRL_IDX;
  assign sel_level = word_idx == gpc_pkg::LEVEL_IDX;
  assign sel_sts   = word_idx == gpc_pkg::IRQ_STS_IDX;
  assign sel_mask  = word_idx == gpc_pkg::IRQ_MASK_IDX;
  assign wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Unmapped words still answer, reading zero, so the master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_ctrl) begin
      next_rdata[15:0] = ctrl;
    end else if (sel_level) begin
      next_rdata[15:0] = level;
    end else if (sel_sts) begin
      next_rdata[1:0] = irq_sts;
    end else if (sel_mask) begin
      next_rdata[1:0] = irq_mask;
    end
  end

  // Reloaded only on a request, so read data holds until the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Reserved control bits stay zero whatever is written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= gpc_pkg::CTRL_RESET;
    end else if (bus_wr && sel_ctrl) begin
      ctrl <= (ctrl & ~(wmask & gpc_pkg::CTRL_WMASK))
            | (wb_dat_i[15:0] & wmask & gpc_pkg::CTRL_WMASK);
    end
  end

  // Only the output level bit is writable; the input bits mirror the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= gpc_pkg::LEVEL_RESET;
    end else begin
      if (bus_wr && sel_level && wb_sel_i[0]) begin
        level[gpc_pkg::LVL_OUT_BIT] <= wb_dat_i[gpc_pkg::LVL_OUT_BIT];
      end
      level[gpc_pkg::LVL_IN_BIT]  <= sense;
      level[gpc_pkg::LVL_RAW_BIT] <= pin_sync;
    end
  end

  // Mask resets to all ones, so nothing reaches the host before setup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= gpc_pkg::IRQ_MASK_RESET;
    end else if (bus_wr && sel_mask && wb_sel_i[0]) begin
      irq_mask <= wb_dat_i[1:0];
    end
  end

  // Pin input path
  gpc_sync2 #(
    .WIDTH (1)
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_in_i),
    .q_o   (pin_sync)
  );

  // Sources arrive from other clock domains, e.g. the oscillator clocks
  gpc_sync2 #(
    .WIDTH (16)
  ) u_src_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (out_src_i),
    .q_o   (src_sync)
  );

  gpc_debounce #(
    .CYCLES (LONG_DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_sync),
    .q_o   (pin_deb)
  );

  assign long_deb = gpc_pkg::LONG_DEB_CODES[f_fn];
  assign raw_sel  = long_deb ? pin_deb : pin_sync;

  // Sense is the asserted state of the pin after polarity
  always_comb begin
    sense = raw_sel;
    if (!f_pol) begin
      sense = ~sense;
    end
  end

  // Edges are taken before polarity, so rewriting the polarity bit never
  // fakes an event; both histories run always, so a code change cannot either
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_prev <= 1'b0;
      deb_prev  <= 1'b0;
    end else begin
      sync_prev <= pin_sync;
      deb_prev  <= pin_deb;
    end
  end

  assign raw_prev = long_deb ? deb_prev : sync_prev;
  assign raw_rise = raw_sel & ~raw_prev;
  assign raw_fall = ~raw_sel & raw_prev;

  always_comb begin
    edge_evt = 1'b0;
    if (in_mode) begin
      if (f_edge_both) begin
        edge_evt = raw_rise | raw_fall;
      end else if (f_pol) begin
        edge_evt = raw_rise;
      end else begin
        edge_evt = raw_fall;
      end
    end
  end

  // Input functions: one level line per function code
  generate
    for (genvar k = 0; k < 16; k++) begin : g_in_fn
      assign next_in_fn[k] = in_mode & (f_fn == 4'(k)) & sense;
    end
  endgenerate

  // Lines are levels; a consumer that needs a pulse takes its own edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_fn_o <= '0;
    end else begin
      in_fn_o <= next_in_fn;
    end
  end

  // A function line turning on is an event of its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_q <= 1'b0;
    end else begin
      sense_q <= |next_in_fn;
    end
  end

  // First cycle only, so a held request sets the status once
  assign fn_evt = (|next_in_fn) & ~sense_q;

  // Interrupts
  // A new event in the same cycle as a clear keeps the bit set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts <= gpc_pkg::IRQ_STS_RESET;
    end else begin
      if (bus_wr && sel_sts && wb_sel_i[0]) begin
        irq_sts <= irq_sts & ~wb_dat_i[1:0];
      end
      if (edge_evt) begin
        irq_sts[gpc_pkg::IRQ_EDGE_BIT] <= 1'b1;
      end
      if (fn_evt) begin
        irq_sts[gpc_pkg::IRQ_FN_BIT] <= 1'b1;
      end
    end
  end

  // Registered, so the line lags the status bit by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_sts & ~irq_mask);
    end
  end

  // Output path
  assign out_rsvd = gpc_pkg::OUT_RSVD_CODES[f_fn];

  // Selected source in asserted terms; code 0 is the software level
  always_comb begin
    if (out_rsvd) begin
      out_level = 1'b0;
    end else if (f_fn == gpc_pkg::FN_OUT_LEVEL) begin
      out_level = level[gpc_pkg::LVL_OUT_BIT];
    end else begin
      out_level = src_sync[f_fn];
    end
  end

  // Polarity applies after the source pick, so reserved codes park inactive
  assign pin_level = f_pol ? out_level : ~out_level;

  always_comb begin
    next_pad            = gpc_pkg::PAD_RESET;
    next_pad.alt_supply = f_dom;
    next_pad.pull_up    = f_pull == gpc_pkg::PULL_UP;
    next_pad.pull_down  = f_pull == gpc_pkg::PULL_DOWN;
    next_pad.out        = 1'b0;
    next_pad.oe         = 1'b0;
    if (out_mode) begin
      if (f_od) begin
        // Open drain only ever sinks; a high level is left to the pull
        next_pad.out = 1'b0;
        next_pad.oe  = ~pin_level;
      end else begin
        next_pad.out = pin_level;
        next_pad.oe  = 1'b1;
      end
    end
    if (out_mode && out_rsvd) begin
      // A parked reserved output gets no resistor fighting its level
      next_pad.pull_up   = 1'b0;
      next_pad.pull_down = 1'b0;
    end
  end

  // Every pad control leaves a flop, so the pins never glitch on a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= gpc_pkg::PAD_RESET;
    end else begin
      pad_o <= next_pad;
    end
  end

endmodule

// file: hw/gpc_pkg.sv
package gpc_pkg;

  // Clock and timing
  localparam int CLK_FREQ_MHZ = 50;
  localparam int LONG_DEBOUNCE_US = 10000;
  localparam int LONG_DEBOUNCE_CYCLES = LONG_DEBOUNCE_US * CLK_FREQ_MHZ;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] CTRL_IDX     = 16'h403A;
  localparam logic [15:0] LEVEL_IDX    = 16'h4040;
  localparam logic [15:0] IRQ_STS_IDX  = 16'h4041;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h4042;

  // Control register fields
  localparam int DIR_BIT  = 15;
  localparam int PULL_HI  = 14;
  localparam int PULL_LO  = 13;
  localparam int EDGE_BIT = 12;
  localparam int DOM_BIT  = 11;
  localparam int POL_BIT  = 10;
  localparam int OD_BIT   = 9;
  localparam int ENA_BIT  = 7;
  localparam int FN_HI    = 3;
  localparam int FN_LO    = 0;
  localparam logic [15:0] CTRL_RESET = 16'hA400;
  localparam logic [15:0] CTRL_WMASK = 16'hFE8F;

  // Level register fields
  localparam int LVL_OUT_BIT  = 0;
  localparam int LVL_IN_BIT   = 1;
  localparam int LVL_RAW_BIT  = 2;
  localparam logic [15:0] LEVEL_RESET = 16'h0000;

  // Interrupt register fields
  localparam int IRQ_EDGE_BIT = 0;
  localparam int IRQ_FN_BIT   = 1;
  localparam logic [1:0] IRQ_STS_RESET  = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;

  // Pull codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;

  // Function code groups, one bit per code
  localparam logic [15:0] LONG_DEB_CODES = 16'hC011;
  localparam logic [15:0] OUT_RSVD_CODES = 16'h00E0;
  localparam logic [3:0]  FN_OUT_LEVEL   = 4'h0;

  typedef logic [15:0] gpc_fn_vec_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic alt_supply;
  } gpc_pad_t;

  localparam gpc_pad_t PAD_RESET = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0,
                                     pull_down: 1'b1, alt_supply: 1'b0};

endpackage

// file: hw/gpc_sync2.sv
`timescale 1ns/1ps
module gpc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// file: verif/gpc_pin_ctrl_asserts.sv
`timescale 1ns/1ps
module gpc_pin_ctrl_asserts (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [17:0]          wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire gpc_pkg::gpc_pad_t    pad_o,
  input wire gpc_pkg::gpc_fn_vec_t in_fn_o,
  input wire logic                 irq_o
);
  logic [15:0] ctrl;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the control word; whole-word writes only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= gpc_pkg::CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                 wb_adr_i[17:2] == gpc_pkg::CTRL_IDX) begin
      ctrl <= wb_dat_i[15:0] & gpc_pkg::CTRL_WMASK;
    end
  end
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rd_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  tristate_a: assert property ($stable(ctrl) && (!ctrl[7] || ctrl[15]) |-> !pad_o.oe)
    else $error("pad driven");
  pull_sel_a: assert property ($stable(ctrl) && !(!ctrl[15] && ctrl[7] &&
    ctrl[3:0] inside {4'h5, 4'h6, 4'h7}) |-> pad_o.pull_up == (ctrl[14:13] == 2'h2) &&
    pad_o.pull_down == (ctrl[14:13] == 2'h1)) else $error("pull wrong");
  supply_sel_a: assert property ($stable(ctrl) |-> pad_o.alt_supply == ctrl[11])
    else $error("supply wrong");
  drain_only_a: assert property ($stable(ctrl) && ctrl[9] |-> !(pad_o.oe && pad_o.out))
    else $error("open drain drove high");
  fn_line_a: assert property ($stable(ctrl) |->
    (in_fn_o & ~(16'h0001 << ctrl[3:0])) == 16'h0000 && (ctrl[15] && ctrl[7] || in_fn_o == 16'h0000))
    else $error("wrong function line");
  rsvd_out_a: assert property ($stable(ctrl) && !ctrl[15] && ctrl[7] && !ctrl[9] &&
    ctrl[3:0] inside {4'h5, 4'h6, 4'h7} |-> pad_o.oe && pad_o.out == !ctrl[10] &&
    !pad_o.pull_up && !pad_o.pull_down)
    else $error("reserved code not inactive");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(irq_o));
  cover property (in_fn_o != 16'h0000);
endmodule

// file: verif/gpc_pin_model.sv
`timescale 1ns/1ps
module gpc_pin_model (
  input  wire logic              clk_i,
  input  wire gpc_pkg::gpc_pad_t pad_i,
  input  wire logic              drive_i,
  input  wire logic              level_i,
  output logic                   pin_o
);
  logic wander = 1'b0;
  // A floating line must not settle to a value the simulator picks
  always_ff @(posedge clk_i) begin
    wander <= !wander;
  end
  always_comb begin
    if (pad_i.oe) begin
      pin_o = pad_i.out;
    end else if (drive_i) begin
      pin_o = level_i;
    end else if (pad_i.pull_up) begin
      pin_o = 1'b1;
    end else if (pad_i.pull_down) begin
      pin_o = 1'b0;
    end else begin
      pin_o = wander;
    end
  end
endmodule

// file: verif/gpio3_pin_control_test.sv
`timescale 1ns/1ps
module gpio3_pin_control_test;
  logic                 clk_i = 1'b0, rst_i = 1'b1, drive = 1'b0, level = 1'b0;
  logic                 wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o, pin_in_i;
  logic [17:0]          wb_adr_i = 18'h00000;
  logic [3:0]           wb_sel_i = 4'hF;
  logic [31:0]          wb_dat_i = 32'h00000000, wb_dat_o, q;
  gpc_pkg::gpc_pad_t    pad_o;
  gpc_pkg::gpc_fn_vec_t out_src_i = 16'h0000, in_fn_o;
  int                   fails = 0, num_checks = 0, cycles = 0;
  always #10 clk_i = !clk_i;
  gpc_pin_ctrl #(.LONG_DEBOUNCE_CYCLES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_in_i(pin_in_i), .pad_o(pad_o), .out_src_i(out_src_i), .in_fn_o(in_fn_o), .irq_o(irq_o));
  gpc_pin_model pin_far (.clk_i(clk_i), .pad_i(pad_o), .drive_i(drive), .level_i(level),
    .pin_o(pin_in_i));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [15:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= wr;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cfg(input logic [15:0] c);
    bus(gpc_pkg::CTRL_IDX, 1'b1, c);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic pad_is(input logic [15:0] c, input logic [1:0] exp);
    cfg(c);
    chk(32'({pad_o.oe, pad_o.oe & pad_o.out}), 32'(exp), "pad drive");
  endtask
  task automatic pulse(input logic lv, input logic exp);
    bus(gpc_pkg::IRQ_STS_IDX, 1'b1, 16'h0003);
    level <= lv;
    repeat (8) @(posedge clk_i);
    chk(32'(irq_o), 32'(exp), "irq level");
  endtask
  task automatic t_reset;
    bus(gpc_pkg::CTRL_IDX, 1'b0, 16'h0000);
    chk(q, 32'h0000A400, "ctrl reset");
    chk(32'(pad_o), 32'(gpc_pkg::PAD_RESET), "pad reset");
    bus(16'h0001, 1'b1, 16'hFFFF);
    bus(16'h0001, 1'b0, 16'h0000);
    chk(q, 32'h00000000, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_pads;
    for (int p = 0; p < 4; p++) begin
      cfg(16'h8C00 | (16'(p) << 13));
      chk(32'({pad_o.pull_up, pad_o.pull_down, pad_o.alt_supply}),
          32'({p == 2, p == 1, 1'b1}), "pull and supply");
    end
    cfg(16'h4485);
    chk(32'({pad_o.pull_up, pad_o.pull_down}), 32'h0, "reserved code pull");
    $display("test pads done");
  endtask
  task automatic t_drive;
    bus(gpc_pkg::LEVEL_IDX, 1'b1, 16'h0001);
    pad_is(16'h0480, 2'b11);
    pad_is(16'h0080, 2'b10);
    pad_is(16'h0680, 2'b00);
    bus(gpc_pkg::LEVEL_IDX, 1'b1, 16'h0000);
    pad_is(16'h0680, 2'b10);
    pad_is(16'h0400, 2'b00);
    for (int k = 1; k < 16; k++) begin
      out_src_i <= 16'h0001 << k;
      pad_is(16'h0480 | 16'(k), (k >= 5 && k <= 7) ? 2'b10 : 2'b11);
      out_src_i <= 16'h0000;
      repeat (6) @(posedge clk_i);
      chk(32'(pad_o.out), 32'h0, "source low");
    end
    $display("test drive done");
  endtask
  task automatic t_inputs;
    drive <= 1'b1;
    level <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      cfg(16'h8480 | 16'(k));
      chk(32'(in_fn_o), 32'(16'h0001 << k), "input line");
    end
    level <= 1'b0;
    cfg(16'h8081);
    chk(32'(in_fn_o), 32'h00000002, "inverted sense");
    $display("test inputs done");
  endtask
  task automatic t_irq;
    bus(gpc_pkg::IRQ_MASK_IDX, 1'b1, 16'h0002);
    cfg(16'h8481);
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b0);
    cfg(16'h8081);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    cfg(16'h9081);
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    bus(gpc_pkg::IRQ_MASK_IDX, 1'b1, 16'h0003);
    pulse(1'b1, 1'b0);
    bus(gpc_pkg::IRQ_STS_IDX, 1'b0, 16'h0000);
    chk(32'(q[0]), 32'h1, "masked status kept");
    $display("test irq done");
  endtask
  task automatic t_debounce;
    level <= 1'b0;
    cfg(16'h8480);
    level <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(32'(in_fn_o), 32'h00000000, "debounce holds");
    repeat (4) @(posedge clk_i);
    chk(32'(in_fn_o), 32'h00000001, "debounce passes");
    bus(gpc_pkg::LEVEL_IDX, 1'b0, 16'h0000);
    chk(q, 32'h00000006, "level mirror");
    level <= 1'b0;
    cfg(16'h8481);
    level <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(32'(in_fn_o), 32'h00000002, "no debounce");
    $display("test debounce done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_pads;
    t_drive;
    t_inputs;
    t_irq;
    t_debounce;
    end_sim;
  end
endmodule
bind gpc_pin_ctrl gpc_pin_ctrl_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_o(pad_o),
  .in_fn_o(in_fn_o), .irq_o(irq_o));
